// file: hdl/sbs_ctrl.sv
// Purpose: Controller end driving the burst memory pins
// Assumes: Same clk as the memory end
// Notes: One request per enabled cycle; reads return four edges later
`timescale 1ns/1ns
`include "sbs_defs.svh"

module sbs_ctrl (
  input wire logic clk,
  input wire logic resetn,
  sbs_link_if.ctrl bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_burst,
  input wire logic [`SBS_ADDR_W-1:0] req_addr,
  input wire logic [`SBS_LANES-1:0] req_lanes,
  input wire logic [`SBS_DATA_W-1:0] req_wdata,
  input wire logic hold_clock,
  input wire logic sleep_in,
  input wire logic interleave_in,
  input wire logic out_enable_in,
  output logic rd_valid,
  output logic [`SBS_DATA_W-1:0] rd_data
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [`SBS_ADDR_W-1:0] addr;
    logic adv;
    logic we_low;
    logic [`SBS_LANES-1:0] lanes_low;
    logic sel;
    logic [`SBS_DATA_W-1:0] wdata0;
    logic s1_valid;
    logic s1_write;
    logic [`SBS_DATA_W-1:0] wdata1;
    logic s2_write;
    logic [`SBS_DATA_W-1:0] wdata2;
    logic s2_read;
    logic s3_read;
    logic [`SBS_DATA_W-1:0] dq_out;
    logic dq_oe;
    logic cen_low;
    logic sleep;
    logic mode;
    logic oe_low;
    logic rd_valid;
    logic [`SBS_DATA_W-1:0] rd_data;
  } sbs_ctrl_state_t;

  sbs_ctrl_state_t st_reg;
  sbs_ctrl_state_t st_next;

  // Requests only move while the gate is open
  assign req_ready = ~st_reg.cen_low;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    st_next = st_reg;
    st_next.rd_valid = 1'h0;
    st_next.cen_low = hold_clock;
    st_next.sleep = sleep_in;
    st_next.mode = interleave_in;
    st_next.oe_low = ~out_enable_in;
    if (!st_reg.cen_low)
    begin
      // Present the next command or a deselect
      st_next.addr = req_addr;
      st_next.adv = req_valid & req_burst;
      st_next.we_low = ~(req_valid & req_write);
      st_next.lanes_low = ~req_lanes;
      st_next.sel = req_valid;
      st_next.wdata0 = req_wdata;
      // Track what the memory sampled this edge
      st_next.s1_valid = st_reg.sel | st_reg.adv;
      st_next.s1_write = ~st_reg.we_low;
      st_next.wdata1 = st_reg.wdata0;
      st_next.wdata2 = st_reg.wdata1;
      st_next.s2_write = st_reg.s1_valid & st_reg.s1_write;
      st_next.s2_read = st_reg.s1_valid & ~st_reg.s1_write;
      st_next.s3_read = st_reg.s2_read;
      // Write data driven from the second edge after sampling, in the read slot
      st_next.dq_out = st_reg.wdata2;
      st_next.dq_oe = st_reg.s2_write;
      // Read data sampled one edge after the memory launches it
      if (st_reg.s3_read)
      begin
        st_next.rd_data = bus.dq_bus;
        st_next.rd_valid = 1'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= '0;
      st_reg.we_low <= 1'h1;
      st_reg.lanes_low <= '1;
      st_reg.oe_low <= 1'h1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins

  assign bus.addr = st_reg.addr;
  assign bus.adv_load = st_reg.adv;
  assign bus.write_enable_low = st_reg.we_low;
  assign bus.byte_lane_write_select_low = st_reg.lanes_low;
  assign bus.chip_select_first_low = ~st_reg.sel;
  assign bus.chip_select_second_high = st_reg.sel;
  assign bus.chip_select_third_low = ~st_reg.sel;
  assign bus.clk_gate_low = st_reg.cen_low;
  assign bus.sleep_request = st_reg.sleep;
  assign bus.burst_interleave = st_reg.mode;
  assign bus.out_drive_low = st_reg.oe_low;
  assign bus.dq_host = st_reg.dq_out;
  assign bus.dq_host_oe = st_reg.dq_oe;
  assign rd_valid = st_reg.rd_valid;
  assign rd_data = st_reg.rd_data;

endmodule // sbs_ctrl

// file: hdl/sbs_mem.sv
// Purpose: Pipelined burst memory end of the link
// Assumes: Controller keeps the pin timing; same clk at both ends
// Notes: Storage is always words of 36 bits; narrow mode uses halves
`timescale 1ns/1ns
`include "sbs_defs.svh"

module sbs_mem (
  input wire logic clk,
  input wire logic resetn,
  sbs_link_if.mem bus
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    sbs_pkg::sbs_stage_t stage1;
    sbs_pkg::sbs_stage_t stage2;
    sbs_pkg::sbs_stage_t stage3;
    sbs_pkg::sbs_cmd_t burst_cmd;
    logic [`SBS_ADDR_W-1:0] burst_base;
    logic [`SBS_BURST_W-1:0] burst_cnt;
    logic [`SBS_DATA_W-1:0] dq_out;
    logic dq_drive;
  } sbs_mem_state_t;

  sbs_mem_state_t st_reg;
  sbs_mem_state_t st_next;

  // Storage array
  logic [`SBS_DATA_W-1:0] mem_array [0:`SBS_WORDS-1];

  logic enabled;
  logic selected;
  logic [`SBS_BURST_W-1:0] cnt_step;
  logic [`SBS_BURST_W-1:0] burst_low;
  logic [`SBS_WORD_ADDR_W-1:0] word_idx;
  logic half_sel;
  logic [`SBS_WORD_ADDR_W-1:0] wr_idx;
  logic wr_half;
  logic [`SBS_DATA_W-1:0] word_wr;
  logic [`SBS_DATA_W-1:0] word_rd;
  logic [`SBS_DATA_W-1:0] wr_data;
  logic [`SBS_LANES-1:0] wr_lanes;
  logic [`SBS_DATA_W-1:0] merged;
  logic [`SBS_DATA_W-1:0] rd_data;
  logic mem_we;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  // Edge counts only with the gate low
  assign enabled = ~bus.clk_gate_low;

  // All three selects must be active
  assign selected = ~bus.chip_select_first_low & bus.chip_select_second_high
                  & ~bus.chip_select_third_low;

  // Next burst position and its address bits
  assign cnt_step = st_reg.burst_cnt + `SBS_BURST_W'(1);

  always_comb
  begin
    if (bus.burst_interleave)
    begin
      burst_low = st_reg.burst_base[`SBS_BURST_W-1:0] ^ cnt_step;
    end
    else
    begin
      burst_low = st_reg.burst_base[`SBS_BURST_W-1:0] + cnt_step;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array addressing: reads launch from stage two, writes land from stage three

  // Wide uses 20 bits; narrow uses bit 0 as half select
  always_comb
  begin
    if (`SBS_WIDE_ORG)
    begin
      word_idx = st_reg.stage2.addr[`SBS_WORD_ADDR_W-1:0];
      half_sel = 1'h0;
      wr_idx = st_reg.stage3.addr[`SBS_WORD_ADDR_W-1:0];
      wr_half = 1'h0;
    end
    else
    begin
      word_idx = st_reg.stage2.addr[`SBS_ADDR_W-1:1];
      half_sel = st_reg.stage2.addr[0];
      wr_idx = st_reg.stage3.addr[`SBS_ADDR_W-1:1];
      wr_half = st_reg.stage3.addr[0];
    end
  end

  // Old word under the write; a read of the word written this edge sees the merge
  assign word_wr = mem_array[wr_idx];
  assign word_rd = (mem_we && (wr_idx == word_idx)) ? merged : mem_array[word_idx];

  // Place write data and lanes on the addressed half
  always_comb
  begin
    if (`SBS_WIDE_ORG)
    begin
      wr_data = bus.dq_bus;
      wr_lanes = ~st_reg.stage3.lanes;
      rd_data = word_rd;
    end
    else
    begin
      wr_data = wr_half ? {bus.dq_bus[`SBS_HALF_W-1:0], `SBS_HALF_W'(0)}
                        : {`SBS_HALF_W'(0), bus.dq_bus[`SBS_HALF_W-1:0]};
      wr_lanes = wr_half ? {~st_reg.stage3.lanes[1:0], 2'h0}
                         : {2'h0, ~st_reg.stage3.lanes[1:0]};
      rd_data = half_sel ? {`SBS_HALF_W'(0), word_rd[`SBS_DATA_W-1:`SBS_HALF_W]}
                         : {`SBS_HALF_W'(0), word_rd[`SBS_HALF_W-1:0]};
    end
  end

  // Merge selected lanes only
  always_comb
  begin
    merged = word_wr;
    for (int i = 0; i < `SBS_LANES; i++)
    begin
      if (wr_lanes[i])
      begin
        merged[i*`SBS_LANE_W +: `SBS_LANE_W] = wr_data[i*`SBS_LANE_W +: `SBS_LANE_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    st_next = st_reg;
    if (enabled)
    begin
      // Pipeline moves one step per enabled edge
      st_next.stage3 = st_reg.stage2;
      st_next.stage2 = st_reg.stage1;
      st_next.stage1.lanes = bus.byte_lane_write_select_low;
      if (bus.sleep_request)
      begin
        // Sleep takes no new access
        st_next.stage1.cmd = sbs_pkg::SBS_IDLE;
        st_next.burst_cmd = sbs_pkg::SBS_IDLE;
      end
      else if (!bus.adv_load)
      begin
        // Load a fresh address or deselect
        st_next.burst_base = bus.addr;
        st_next.burst_cnt = '0;
        st_next.stage1.addr = bus.addr;
        if (selected)
        begin
          st_next.stage1.cmd = bus.write_enable_low ? sbs_pkg::SBS_READ
                                                     : sbs_pkg::SBS_WRITE;
        end
        else
        begin
          st_next.stage1.cmd = sbs_pkg::SBS_IDLE;
        end
        st_next.burst_cmd = st_next.stage1.cmd;
      end
      else
      begin
        // Advance inside the four word burst
        st_next.burst_cnt = cnt_step;
        st_next.stage1.cmd = st_reg.burst_cmd;
        st_next.stage1.addr = {st_reg.burst_base[`SBS_ADDR_W-1:`SBS_BURST_W], burst_low};
      end
      // Output register launches read data
      if (st_reg.stage2.cmd == sbs_pkg::SBS_READ)
      begin
        st_next.dq_out = rd_data;
        st_next.dq_drive = 1'h1;
      end
      else
      begin
        st_next.dq_drive = 1'h0;
      end
    end
  end

  // Write lands on the same edge that takes its data, one after the read slot
  assign mem_we = enabled && (st_reg.stage3.cmd == sbs_pkg::SBS_WRITE);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Array write, untouched by reset or sleep
  always_ff @(posedge clk)
  begin
    if (mem_we)
    begin
      mem_array[wr_idx] <= merged;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive

  assign bus.dq_dev = st_reg.dq_out;

  // Drive enable is asynchronous; sleep also blanks
  assign bus.dq_dev_oe = st_reg.dq_drive & ~bus.out_drive_low
                       & ~bus.sleep_request;

endmodule // sbs_mem

// file: pkg/sbs_defs.svh
// Purpose: Constants for the pipelined burst memory and its host end
// Assumes: One clock, both ends sample on the rising edge
// Notes: Organisation is picked by SBS_WIDE_ORG (1 = 1M x 36, 0 = 2M x 18)
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH

// Pin widths cover both organisations
`define SBS_ADDR_W 21
`define SBS_DATA_W 36
`define SBS_LANES 4
`define SBS_LANE_W 9
`define SBS_HALF_W 18
// Storage words and index width
`define SBS_WORD_ADDR_W 20
`define SBS_WORDS 1048576
// Organisation select
`define SBS_WIDE_ORG 1'h1
// Burst wraps after four words
`define SBS_BURST_W 2
// Read data pipeline depth in enabled edges
`define SBS_READ_LATENCY 2

`endif

// file: pkg/sbs_link_if.sv
// Purpose: Pins between the memory and its controller
// Assumes: Both ends run on the same clk
// Notes: Data bus level is resolved here from the two enables
`timescale 1ns/1ns
`include "sbs_defs.svh"

interface sbs_link_if;
  logic [`SBS_ADDR_W-1:0] addr;
  logic adv_load;
  logic write_enable_low;
  logic [`SBS_LANES-1:0] byte_lane_write_select_low;
  logic chip_select_first_low;
  logic chip_select_second_high;
  logic chip_select_third_low;
  logic clk_gate_low;
  logic sleep_request;
  logic burst_interleave;
  logic out_drive_low;
  logic [`SBS_DATA_W-1:0] dq_dev;
  logic dq_dev_oe;
  logic [`SBS_DATA_W-1:0] dq_host;
  logic dq_host_oe;
  logic [`SBS_DATA_W-1:0] dq_bus;

  // Wire level of the shared data bus
  assign dq_bus = dq_dev_oe ? dq_dev : (dq_host_oe ? dq_host : '0);

  modport mem (
    input addr, adv_load, write_enable_low, byte_lane_write_select_low,
    input chip_select_first_low, chip_select_second_high, chip_select_third_low,
    input clk_gate_low, sleep_request, burst_interleave, out_drive_low, dq_bus,
    output dq_dev, dq_dev_oe
  );

  modport ctrl (
    output addr, adv_load, write_enable_low, byte_lane_write_select_low,
    output chip_select_first_low, chip_select_second_high, chip_select_third_low,
    output clk_gate_low, sleep_request, burst_interleave, out_drive_low,
    output dq_host, dq_host_oe,
    input dq_bus
  );
endinterface

// file: pkg/sbs_pkg.sv
// Purpose: Types shared by both ends of the burst memory link
// Assumes: sbs_defs.svh gives every width
// Notes: No values live here, only types
`include "sbs_defs.svh"

package sbs_pkg;

  // Operation carried through the pipeline
  typedef enum logic [1:0] {SBS_IDLE, SBS_READ, SBS_WRITE} sbs_cmd_t;

  // One captured access
  typedef struct packed {
    sbs_cmd_t cmd;
    logic [`SBS_ADDR_W-1:0] addr;
    logic [`SBS_LANES-1:0] lanes;
  } sbs_stage_t;

endpackage

// file: test/sbs_link_monitor.sv
// Purpose: Assertions on the pins between the memory and its controller
// Assumes: One clock, asynchronous active-low reset
// Notes: Watches interface signals handed in as plain inputs
`timescale 1ns/1ns
`include "sbs_defs.svh"

module sbs_link_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic adv_load,
  input wire logic write_enable_low,
  input wire logic chip_select_first_low,
  input wire logic chip_select_second_high,
  input wire logic chip_select_third_low,
  input wire logic clk_gate_low,
  input wire logic sleep_request,
  input wire logic out_drive_low,
  input wire logic [`SBS_DATA_W-1:0] dq_dev,
  input wire logic dq_dev_oe,
  input wire logic dq_host_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Decode of the sampled pins
  logic sel;
  logic ld;
  assign sel = !chip_select_first_low && chip_select_second_high && !chip_select_third_low;
  assign ld = !clk_gate_low && !adv_load && !sleep_request;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Data phase timing and output blanking
  a_read_drives: assert property (ld && sel && write_enable_low ##1 !clk_gate_low ##1
    !clk_gate_low ##1 (!out_drive_low && !sleep_request) |-> dq_dev_oe)
    else $error("read data not driven two edges after command");
  a_read_not_early: assert property (ld && !sel ##1 ld && sel && write_enable_low
    ##1 !clk_gate_low |=> !dq_dev_oe) else $error("read data driven too early");
  a_write_quiet: assert property (ld && sel && !write_enable_low ##1 !clk_gate_low
    ##1 !clk_gate_low |=> !dq_dev_oe) else $error("memory drives during write");
  a_deselect_quiet: assert property (ld && !sel ##1 !clk_gate_low ##1 !clk_gate_low
    |=> !dq_dev_oe) else $error("deselected cycle drove data");
  a_write_data_drive: assert property (ld && sel && !write_enable_low ##1 !clk_gate_low
    ##1 !clk_gate_low |=> dq_host_oe) else $error("write data not driven in its slot");
  a_no_overlap: assert property (!(dq_dev_oe && dq_host_oe))
    else $error("both ends drive the data bus");
  a_drive_blank: assert property (out_drive_low |-> !dq_dev_oe)
    else $error("output enable high while drive enable off");
  a_sleep_blank: assert property (sleep_request |-> !dq_dev_oe)
    else $error("output driven during sleep");
  a_gate_freeze: assert property (clk_gate_low |=> $stable(dq_dev))
    else $error("data output moved on a gated edge");

  // Main scenarios
  c_read: cover property (ld && sel && write_enable_low);
  c_write: cover property (ld && sel && !write_enable_low);
  c_gate: cover property (clk_gate_low ##1 dq_dev_oe);
endmodule // sbs_link_monitor

// file: test/tb.sv
// Purpose: Self-checking bench driving the controller against the memory
// Assumes: Wide organisation, reads return in order on rd_valid
// Notes: A word model predicts every read
`timescale 1ns/1ns
`include "sbs_defs.svh"

module tb;
  logic clk;
  logic resetn;
  logic req_valid;
  logic req_ready;
  logic req_write;
  logic req_burst;
  logic [`SBS_ADDR_W-1:0] req_addr;
  logic [`SBS_LANES-1:0] req_lanes;
  logic [`SBS_DATA_W-1:0] req_wdata;
  logic hold_clock;
  logic sleep_in;
  logic interleave_in;
  logic out_enable_in;
  logic rd_valid;
  logic [`SBS_DATA_W-1:0] rd_data;
  logic blank;
  logic [`SBS_ADDR_W-1:0] base;
  logic [`SBS_DATA_W-1:0] model [int];
  logic [`SBS_DATA_W-1:0] expq [$];
  int errors;
  int total_checks;

  sbs_link_if link ();
  sbs_mem i_sbs_mem (.clk(clk), .resetn(resetn), .bus(link.mem));
  sbs_ctrl i_sbs_ctrl (.clk(clk), .resetn(resetn), .bus(link.ctrl), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_burst(req_burst), .req_addr(req_addr),
    .req_lanes(req_lanes), .req_wdata(req_wdata), .hold_clock(hold_clock),
    .sleep_in(sleep_in), .interleave_in(interleave_in), .out_enable_in(out_enable_in),
    .rd_valid(rd_valid), .rd_data(rd_data));
  sbs_link_monitor i_sbs_link_monitor (.clk(clk), .resetn(resetn), .adv_load(link.adv_load),
    .write_enable_low(link.write_enable_low),
    .chip_select_first_low(link.chip_select_first_low),
    .chip_select_second_high(link.chip_select_second_high),
    .chip_select_third_low(link.chip_select_third_low), .clk_gate_low(link.clk_gate_low),
    .sleep_request(link.sleep_request), .out_drive_low(link.out_drive_low),
    .dq_dev(link.dq_dev), .dq_dev_oe(link.dq_dev_oe), .dq_host_oe(link.dq_host_oe));

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and timing helpers
  task automatic check(input logic [`SBS_DATA_W-1:0] seen, input logic [`SBS_DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp || $isunknown(seen))
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic idle(input int n);
    req_valid = 1'b0;
    req_burst = 1'b0;
    tick(n);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  // One request, held until an edge with ready high takes it
  task automatic op(input logic w, input logic b, input logic [`SBS_ADDR_W-1:0] a,
    input logic [`SBS_LANES-1:0] ln, input logic [`SBS_DATA_W-1:0] d);
    int n;
    req_valid = 1'b1;
    req_write = w;
    req_burst = b;
    req_addr = a;
    req_lanes = ln;
    req_wdata = d;
    n = 0;
    while (req_ready !== 1'b1)
    begin
      tick(1);
      n++;
      if (n > 20)
      begin
        errors++;
        give_verdict();
      end
    end
    tick(1);
    for (int i = 0; i < `SBS_LANES; i++)
      if (w && ln[i])
        model[int'(a)][i*`SBS_LANE_W +: `SBS_LANE_W] = d[i*`SBS_LANE_W +: `SBS_LANE_W];
    if (!w)
      expq.push_back(blank ? 36'h0 : model[int'(a)]);
  endtask

  // Four-word burst: load, then three advances in the strapped order
  task automatic burst(input logic w, input logic [`SBS_ADDR_W-1:0] a,
    input logic [`SBS_DATA_W-1:0] d);
    logic [1:0] lo;
    for (int k = 0; k < 4; k++)
    begin
      lo = interleave_in ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k));
      op(w, k != 0, {a[`SBS_ADDR_W-1:2], lo}, 4'hF, d + 36'(k));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Every returned word against the oldest expectation
  always @(posedge clk)
    if (resetn === 1'b1 && rd_valid === 1'b1)
    begin
      if (expq.size() > 0)
        check(rd_data, expq.pop_front());
      else
        check(36'(expq.size()), 36'h1);
    end

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_burst = 1'b0;
    req_addr = 21'h0;
    req_lanes = 4'h0;
    req_wdata = 36'h0;
    hold_clock = 1'b0;
    sleep_in = 1'b0;
    interleave_in = 1'b0;
    out_enable_in = 1'b1;
    blank = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    #1;
    resetn = 1'b1;
    tick(1);
    // Back-to-back writes, reads, then read/write turnarounds on one word
    for (int i = 0; i < 4; i++)
      op(1'b1, 1'b0, 21'(i * 3), 4'hF, 36'h1_2345_6780 + 36'(i));
    for (int i = 0; i < 4; i++)
      op(1'b0, 1'b0, 21'(i * 3), 4'hF, 36'h0);
    op(1'b0, 1'b0, 21'h3, 4'hF, 36'h0);
    op(1'b1, 1'b0, 21'h3, 4'hF, 36'hA_BCDE_F012);
    op(1'b0, 1'b0, 21'h3, 4'hF, 36'h0);
    // Lane masks: none, each single lane, each followed by a read
    op(1'b1, 1'b0, 21'h40, 4'hF, 36'hF_FFFF_FFFF);
    for (int i = 0; i < 5; i++)
    begin
      op(1'b1, 1'b0, 21'h40, 4'((1 << i) >> 1), 36'h5_5555_5555 * 36'(i));
      op(1'b0, 1'b0, 21'h40, 4'hF, 36'h0);
    end
    // Bursts in both orders, read back by burst and by single loads
    for (int m = 0; m < 2; m++)
    begin
      idle(2);
      interleave_in = m[0];
      idle(2);
      base = m[0] ? 21'h20E : 21'h105;
      burst(1'b1, base, 36'h7_0000_0010 * 36'(m + 1));
      burst(1'b0, base, 36'h0);
      for (int k = 0; k < 4; k++)
        op(1'b0, 1'b0, {base[`SBS_ADDR_W-1:2], 2'(k)}, 4'hF, 36'h0);
    end
    // Clock gate held for three edges in mid-stream
    fork
      begin
        tick(2);
        hold_clock = 1'b1;
        tick(3);
        hold_clock = 1'b0;
      end
      for (int i = 0; i < 6; i++)
        op(i[0], 1'b0, 21'((i >> 1) * 3), 4'hF, 36'h9_0000_0000 + 36'(i));
    join
    // Output drive off, then sleep, then contents after sleep
    idle(4);
    out_enable_in = 1'b0;
    blank = 1'b1;
    idle(1);
    op(1'b0, 1'b0, 21'h3, 4'hF, 36'h0);
    idle(8);
    out_enable_in = 1'b1;
    sleep_in = 1'b1;
    idle(2);
    op(1'b0, 1'b0, 21'h40, 4'hF, 36'h0);
    idle(8);
    sleep_in = 1'b0;
    blank = 1'b0;
    idle(3);
    op(1'b0, 1'b0, 21'h40, 4'hF, 36'h0);
    idle(12);
    check(36'(expq.size()), 36'h0);
    give_verdict();
  end
endmodule // tb
